//--- cell_desc_fifo.sv
/*
  Descriptor FIFO, width and depth as parameters, valid/ready on both
  sides. Assumes sys_clk domain, synchronous active-low reset, clk_en.
*/
`timescale 1ns/1ps
module cell_desc_fifo #(
  parameter int W     = 28,
  parameter int DEPTH = 8
) (
  input wire logic   sys_clk,
  input wire logic   rst_b,
  input wire logic   clk_en,
  cell_stream_if.snk in_s,
  cell_stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin
      $error("cell_desc_fifo depth must be a power of two of at least 2");
    end
  end

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW:0]   wp_q;
  logic [PW:0]   rp_q;
  wire           empty = (wp_q == rp_q);
  wire           full  = (wp_q[PW-1:0] == rp_q[PW-1:0]) && (wp_q[PW] != rp_q[PW]);
  wire           push  = in_s.valid && !full;
  wire           pop   = out_s.ready && !empty;

  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem_q[rp_q[PW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (clk_en) begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_q[wp_q[PW-1:0]] <= in_s.data;
    end
  end
endmodule

//--- cell_stream_if.sv
/*
  Valid/ready carrier for queued cell descriptors between the register
  block and its descriptor FIFO. Assumes one clock for both ends.
*/
`timescale 1ns/1ps
interface cell_stream_if #(parameter int W = 28);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- seg_model.sv
/*
  Segmenter stand-in: takes descriptors with random stalls, reports
  finished cells later. Assumes clk_en held high.
*/
`timescale 1ns/1ps
module seg_model (
  input  wire logic sys_clk,
  input  wire logic cell_valid,
  output logic      cell_ready,
  output logic      cell_done
);
  int owed = 0;
  int seed = 32'h1234_abcd;
  initial begin
    cell_ready = 1'b0;
    cell_done  = 1'b0;
  end
  always @(posedge sys_clk) begin
    if (cell_valid && cell_ready)
      owed++;
    if (cell_done)
      owed--;
    #1;
    cell_ready = ($random(seed) % 4) != 0;
    // Done only for cells taken, so the cell in flight stays valid until then
    cell_done = owed > 0 && ($random(seed) % 3) == 0;
  end
endmodule

//--- tb.sv
/*
  Testbench: register map, address forming and issue order for every size.
  Assumes the checker is bound and the segmenter stand-in takes cells.
*/
`timescale 1ns/1ps
module tb;
  import tx_cell_queue_pkg::*;
  logic        sys_clk, rst_b, clk_en, cpu_wr, cpu_rd, cell_queue_enable;
  logic        cell_valid, cell_ready, cell_done, queue_empty;
  logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, d;
  logic [11:0] sched_entry, base;
  logic [20:0] ctrl_struct_addr, cell_addr;
  logic [6:0]  cell_index, exp_idx;
  logic [7:0]  cap;
  logic [15:0] map [5] = '{OFS_CTRL_BASE, OFS_QUEUE_BASE, OFS_WR_INDEX, OFS_RD_INDEX, 16'h2042};
  int          num_errors = 0, n_checks = 0, seed = 32'hf251_8669;

  tx_cell_queue_regs i_tx_cell_queue_regs (.*);
  seg_model i_seg_model (.*);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] mask(logic [15:0] a, logic [15:0] v);
    case (a)
      OFS_CTRL_BASE:  return v & 16'h001f;
      OFS_QUEUE_BASE: return v & 16'h3fff;
      OFS_WR_INDEX:   return v & 16'h00ff;
      default:        return 16'h0000;
    endcase
  endfunction

  task automatic chk(string what, logic [20:0] exp, logic [20:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(logic w, logic [15:0] a, logic [15:0] v);
    cpu_addr  = a;
    cpu_wdata = v;
    cpu_wr    = w;
    cpu_rd    = !w;
    @(posedge sys_clk);
    #1;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(logic [15:0] a, logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk("read data", {5'h00, exp}, {5'h00, cpu_rdata});
  endtask

  task automatic wait_empty;
    repeat (2000) if (!queue_empty) @(posedge sys_clk);
    #1;
    chk("queue drained", 21'h1, {20'h0, queue_empty});
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Issue order and address of every taken descriptor
  always @(posedge sys_clk) begin
    if (cell_valid && cell_ready && clk_en) begin
      chk("cell index", {14'h0, exp_idx}, {14'h0, cell_index});
      chk("cell address", {base, 9'h000} + {exp_idx, 6'h00}, cell_addr);
      exp_idx = ({1'b0, exp_idx} == cap - 8'h01) ? 7'h00 : exp_idx + 7'h01;
    end
  end

  initial begin
    {rst_b, cpu_wr, cpu_rd, cell_queue_enable} = 4'h0;
    {cpu_addr, cpu_wdata, sched_entry, base} = 56'h0;
    {clk_en, exp_idx, cap} = 16'h8010;
    repeat (5) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    foreach (map[i]) rd(map[i], 16'h0000);
    repeat (3) foreach (map[i]) begin
      d = 16'($random(seed));
      bus(1'b1, map[i], d);
      rd(map[i], mask(map[i], d));
    end
    repeat (4) begin
      d = 16'($random(seed));
      sched_entry = d[11:0];
      // Queue stays disabled here, so base changes are legal
      bus(1'b1, OFS_CTRL_BASE, d);
      chk("control address", {d[4:0], d[11:0], 4'h0}, ctrl_struct_addr);
    end
    // Frozen clock enable must swallow the write
    clk_en = 1'b0;
    bus(1'b1, OFS_CTRL_BASE, ~d);
    clk_en = 1'b1;
    rd(OFS_CTRL_BASE, mask(OFS_CTRL_BASE, d));
    for (int s = 0; s < 4; s++) begin
      rst_b = 1'b0;
      @(posedge sys_clk);
      #1 rst_b = 1'b1;
      cap = 8'h10 << s;
      exp_idx = 7'h00;
      // Aligned so even 128 cells stay inside one 8 Kbyte region
      base = 12'($random(seed)) & 12'hff0;
      bus(1'b1, OFS_QUEUE_BASE, {2'b00, 2'(s), base});
      cell_queue_enable = 1'b1;
      bus(1'b1, OFS_WR_INDEX, {8'h00, cap - 8'h01});
      wait_empty;
      bus(1'b1, OFS_RD_INDEX, 16'hffff);
      bus(1'b1, OFS_WR_INDEX, 16'h0003);
      wait_empty;
      rd(OFS_RD_INDEX, 16'h0003);
      cell_queue_enable = 1'b0;
    end
    stop_test;
  end

  // Several times the longest expected run
  initial begin
    #200_000;
    num_errors++;
    stop_test;
  end
endmodule

//--- tx_cell_queue_pkg.sv
/*
  Shared constants for the transmit cell queue register block: register
  offsets, field positions, reset values and queue size encodings.
  Assumes a 16-bit processor port addressed by byte offset.
*/
package tx_cell_queue_pkg;
  localparam int          CPU_AW = 16;
  localparam int          CPU_DW = 16;
  localparam int          MEM_AW = 21;
  localparam int          IDX_W  = 7;
  localparam int          WPTR_W = 8;

  localparam logic [15:0] OFS_CTRL_BASE  = 16'h2040;
  localparam logic [15:0] OFS_QUEUE_BASE = 16'h2050;
  localparam logic [15:0] OFS_WR_INDEX   = 16'h2052;
  localparam logic [15:0] OFS_RD_INDEX   = 16'h2054;
  localparam logic [15:0] REG_RESET      = 16'h0000;

  // Field layout
  localparam int          CTRL_BASE_W  = 5;
  localparam int          QBASE_LSB    = 0;
  localparam int          QBASE_W      = 12;
  localparam int          QSIZE_LSB    = 12;
  localparam int          QSIZE_W      = 2;
  localparam int          ENTRY_W      = 12;
  localparam int          ENTRY_SHIFT  = 4;
  localparam int          QBASE_SHIFT  = 9;
  localparam int          CELL_SHIFT   = 6;

  typedef enum logic [1:0] {
    QSIZE_16  = 2'h0,
    QSIZE_32  = 2'h1,
    QSIZE_64  = 2'h2,
    QSIZE_128 = 2'h3
  } qsize_t;

  localparam logic [IDX_W-1:0] LAST_16  = 7'h0f;
  localparam logic [IDX_W-1:0] LAST_32  = 7'h1f;
  localparam logic [IDX_W-1:0] LAST_64  = 7'h3f;
  localparam logic [IDX_W-1:0] LAST_128 = 7'h7f;
  localparam logic [IDX_W-1:0] IDX_ZERO = 7'h00;

  localparam int          FIFO_DEPTH = 8;
  localparam int          FIFO_W     = MEM_AW + IDX_W;
endpackage

//--- tx_cell_queue_regs.sv
/*
  Transmit cell queue registers: control structure base, queue base and
  size, write index and read index, plus descriptor issue toward the
  transmit segmenter through an 8-word FIFO. Assumes a 16-bit processor
  port with single-cycle read and write strobes, all on sys_clk.
*/
// Notes on behaviour
// - Control structure address: bits 20:16 from base, 15:4 from scheduler entry.
// - Queue start address is base field at bits 20:9, low nine bits zero.
// - Each queued cell owns 64 bytes: entry n at base plus n times 64.
// - Size codes 00,01,10,11 mean 16, 32, 64, 128 cells.
// - Write index is read/write; the cell it names is not yet valid.
// - Read index is read-only, names cell in transmission, still valid.
// - Unused upper bits read zero; all four registers reset to zero.
`timescale 1ns/1ps
module tx_cell_queue_regs
  import tx_cell_queue_pkg::*;
#(
  parameter int FIFO_DEPTH_P = tx_cell_queue_pkg::FIFO_DEPTH
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst_b,
  input  wire logic                                   clk_en,
  input  wire logic [tx_cell_queue_pkg::CPU_AW-1:0]   cpu_addr,
  input  wire logic                                   cpu_wr,
  input  wire logic                                   cpu_rd,
  input  wire logic [tx_cell_queue_pkg::CPU_DW-1:0]   cpu_wdata,
  output logic      [tx_cell_queue_pkg::CPU_DW-1:0]   cpu_rdata,
  input  wire logic                                   cell_queue_enable,
  input  wire logic [tx_cell_queue_pkg::ENTRY_W-1:0]  sched_entry,
  output logic      [tx_cell_queue_pkg::MEM_AW-1:0]   ctrl_struct_addr,
  output logic                                        cell_valid,
  input  wire logic                                   cell_ready,
  output logic      [tx_cell_queue_pkg::MEM_AW-1:0]   cell_addr,
  output logic      [tx_cell_queue_pkg::IDX_W-1:0]    cell_index,
  input  wire logic                                   cell_done,
  output logic                                        queue_empty
);
  import tx_cell_queue_pkg::*;

  initial begin
    if (FIFO_DEPTH_P < 2) begin
      $error("tx_cell_queue_regs needs a FIFO depth of at least 2");
    end
  end

  // Index of the last cell for a size code
  function automatic logic [IDX_W-1:0] last_index(input logic [QSIZE_W-1:0] code);
    case (code)
      QSIZE_16:  last_index = LAST_16;
      QSIZE_32:  last_index = LAST_32;
      QSIZE_64:  last_index = LAST_64;
      QSIZE_128: last_index = LAST_128;
      default:   last_index = LAST_16;
    endcase
  endfunction

  function automatic logic [IDX_W-1:0] next_index(input logic [IDX_W-1:0]   idx,
                                                 input logic [QSIZE_W-1:0] code);
    next_index = (idx >= last_index(code)) ? IDX_ZERO : idx + 1'b1;
  endfunction

  logic [CTRL_BASE_W-1:0] ctrl_base_q;
  logic [QBASE_W-1:0]     qbase_q;
  logic [QSIZE_W-1:0]     qsize_q;
  logic [WPTR_W-1:0]      wr_idx_q;
  logic [IDX_W-1:0]       rd_idx_q;
  logic [IDX_W-1:0]       rd_idx_d;
  logic [IDX_W-1:0]       issue_idx_q;
  logic [IDX_W-1:0]       issue_idx_d;
  logic [CPU_DW-1:0]      rdata_q;
  logic [MEM_AW-1:0]      ctrl_addr_q;

  // Register decode
  wire sel_ctrl  = (cpu_addr == OFS_CTRL_BASE);
  wire sel_qbase = (cpu_addr == OFS_QUEUE_BASE);
  wire sel_wr    = (cpu_addr == OFS_WR_INDEX);
  wire sel_rd    = (cpu_addr == OFS_RD_INDEX);

  // Read view, unused bits zero-filled
  wire [CPU_DW-1:0] rd_ctrl  = {{(CPU_DW-CTRL_BASE_W){1'b0}}, ctrl_base_q};
  wire [CPU_DW-1:0] rd_qbase = {{(CPU_DW-QSIZE_LSB-QSIZE_W){1'b0}},
                                qsize_q, qbase_q};
  wire [CPU_DW-1:0] rd_wr    = {{(CPU_DW-WPTR_W){1'b0}}, wr_idx_q};
  wire [CPU_DW-1:0] rd_rd    = {{(CPU_DW-IDX_W){1'b0}}, rd_idx_q};
  wire [CPU_DW-1:0] rd_mux   = sel_ctrl  ? rd_ctrl  :
                               sel_qbase ? rd_qbase :
                               sel_wr    ? rd_wr    :
                               sel_rd    ? rd_rd    : REG_RESET;

  // Queue state; low seven bits of the write index name the cell
  wire [IDX_W-1:0] wr_cell   = wr_idx_q[IDX_W-1:0];
  wire             empty_now = (rd_idx_q == wr_cell);
  wire             more_cells = (issue_idx_q != wr_cell);

  // Cell address: base at bits 20:9 plus index times 64
  wire [MEM_AW-1:0] qstart   = MEM_AW'({qbase_q, {QBASE_SHIFT{1'b0}}});
  wire [MEM_AW-1:0] cell_ofs = MEM_AW'({issue_idx_q, {CELL_SHIFT{1'b0}}});
  wire [MEM_AW-1:0] issue_addr = qstart + cell_ofs;

  cell_stream_if #(.W(FIFO_W)) push_s ();
  cell_stream_if #(.W(FIFO_W)) pop_s ();

  // Issue stops at the cell software is still filling or when FIFO is full
  assign push_s.valid = cell_queue_enable && more_cells;
  assign push_s.data  = {issue_addr, issue_idx_q};
  wire   push_fire    = push_s.valid && push_s.ready;

  cell_desc_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .in_s    (push_s),
    .out_s   (pop_s)
  );

  assign cell_valid   = pop_s.valid;
  assign pop_s.ready  = cell_ready;
  assign cell_addr    = pop_s.data[FIFO_W-1:IDX_W];
  assign cell_index   = pop_s.data[IDX_W-1:0];

  // Read index leaves a cell only when its transmission completes
  assign rd_idx_d    = (cell_done && !empty_now) ? next_index(rd_idx_q, qsize_q)
                                                 : rd_idx_q;
  assign issue_idx_d = push_fire ? next_index(issue_idx_q, qsize_q) : issue_idx_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_base_q <= CTRL_BASE_W'(REG_RESET);
      qbase_q     <= QBASE_W'(REG_RESET);
      qsize_q     <= QSIZE_W'(REG_RESET);
      wr_idx_q    <= WPTR_W'(REG_RESET);
    end else if (clk_en && cpu_wr) begin
      if (sel_ctrl) begin
        ctrl_base_q <= cpu_wdata[CTRL_BASE_W-1:0];
      end
      if (sel_qbase) begin
        qbase_q <= cpu_wdata[QBASE_LSB +: QBASE_W];
        qsize_q <= cpu_wdata[QSIZE_LSB +: QSIZE_W];
      end
      if (sel_wr) begin
        wr_idx_q <= cpu_wdata[WPTR_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rd_idx_q    <= IDX_ZERO;
      issue_idx_q <= IDX_ZERO;
    end else if (clk_en) begin
      rd_idx_q    <= rd_idx_d;
      issue_idx_q <= issue_idx_d;
    end
  end

  // Control structure address is registered to keep the memory path short
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_addr_q <= '0;
      rdata_q     <= REG_RESET;
    end else if (clk_en) begin
      ctrl_addr_q <= {ctrl_base_q, sched_entry, {ENTRY_SHIFT{1'b0}}};
      if (cpu_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign cpu_rdata        = rdata_q;
  assign ctrl_struct_addr = ctrl_addr_q;
  assign queue_empty      = empty_now;
endmodule

//--- tx_cell_queue_sva.sv
/*
  Port checker for the transmit cell queue registers.
  Assumes one clock, synchronous active-low reset; bound to every instance.
*/
`timescale 1ns/1ps
module tx_cell_queue_sva
  import tx_cell_queue_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [15:0] cpu_rdata,
  input wire logic [11:0] sched_entry,
  input wire logic [20:0] ctrl_struct_addr,
  input wire logic        cell_valid,
  input wire logic        cell_ready,
  input wire logic [20:0] cell_addr,
  input wire logic [6:0]  cell_index,
  input wire logic        cell_done,
  input wire logic        queue_empty
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire rd_ok = cpu_rd && clk_en;
  wire pop   = cell_valid && cell_ready && clk_en;
  wire known = cpu_addr inside {OFS_CTRL_BASE, OFS_QUEUE_BASE, OFS_WR_INDEX, OFS_RD_INDEX};

  a_ctrl_low_bits: assert property (clk_en |=> ctrl_struct_addr[15:0] == {$past(sched_entry), 4'h0})
    else $error("control address low bits wrong");
  a_cell_offset: assert property (cell_valid |-> cell_addr[8:0] == {cell_index[2:0], 6'h00})
    else $error("cell address offset wrong");
  a_ctrl_rsvd_zero: assert property (rd_ok && cpu_addr == OFS_CTRL_BASE |=> cpu_rdata[15:5] == 0)
    else $error("control base upper bits not zero");
  a_rd_rsvd_zero: assert property (rd_ok && cpu_addr == OFS_RD_INDEX |=> cpu_rdata[15:7] == 0)
    else $error("read index upper bits not zero");
  a_unmapped_zero: assert property (rd_ok && !known |=> cpu_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_head_hold: assert property (cell_valid && !(cell_ready && clk_en) |=> cell_valid && $stable(cell_index) && $stable(cell_addr))
    else $error("head descriptor changed while stalled");
  a_empty_no_issue: assert property (queue_empty && !cell_valid && clk_en && !cpu_wr |=> !cell_valid)
    else $error("cell issued from empty queue");
  a_empty_done: assert property (queue_empty && cell_done && clk_en && !cpu_wr |=> queue_empty)
    else $error("done moved read index of empty queue");
  a_index_step: assert property (pop |=> !cell_valid || cell_index == $past(cell_index) + 7'h01 || cell_index == 7'h00)
    else $error("cell index out of order");

  c_pop: cover property (pop);
  c_last_128: cover property (pop && cell_index == LAST_128);
  c_unmapped: cover property (rd_ok && !known);
endmodule

bind tx_cell_queue_regs tx_cell_queue_sva i_tx_cell_queue_sva (.*);
